// ==== core/event_flag.sv ====
// One sticky event flag with software write and hardware set.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module event_flag (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Sync reset
    input  wire logic set_pulse, // Hardware event
    input  wire logic wr_en,     // Software write strobe
    input  wire logic wr_bit,    // Software written value
    output logic      flag       // Flag state
);
    // ----------------------------------------
    // Flag storage
    // ----------------------------------------
    // Set wins over a software write of zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (wr_en) begin
            flag <= wr_bit;
        end
    end
endmodule

// ==== core/quadrature_decoder_evt_map.svh ====
// Register offsets, field positions and reset values of the event block.
// Assumes inclusion by bare name from design and test files.
`ifndef QUAD_EVT_MAP_SVH
`define QUAD_EVT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_NEW_SAMPLE_EVENT   12'h100
`define OFS_MOTION_REPORT_EVT  12'h104
`define OFS_OVERFLOW_EVT       12'h108
`define OFS_DOUBLE_EVT         12'h10c
`define OFS_HALTED_EVT         12'h110
`define OFS_LINKS              12'h200
`define OFS_IRQ_STATUS         12'h300
`define OFS_IRQ_MASK           12'h304
`define OFS_MOTION_SNAP        12'h518
`define OFS_DOUBLE_SNAP        12'h548

// ----------------------------------------
// Link bit positions
// ----------------------------------------
`define LNK_REPORT_CLR_BOTH    0
`define LNK_SAMPLE_STOP        1
`define LNK_REPORT_CLR_MOTION  2
`define LNK_REPORT_STOP        3
`define LNK_DOUBLE_CLR_DOUBLE  4
`define LNK_DOUBLE_STOP        5
`define LNK_SAMPLE_CLR_BOTH    6
`define LINKS_WIDTH            7
`define LINKS_RESET            7'h00

// ----------------------------------------
// Event index in status and mask
// ----------------------------------------
`define EV_SAMPLE              0
`define EV_REPORT              1
`define EV_OVERFLOW            2
`define EV_DOUBLE              3
`define EV_HALTED              4
`define EV_COUNT               5

`endif

// ==== core/quadrature_decoder_evt_pkg.sv ====
// Types shared by the event block.
// Assumes the map header for numeric constants.
package quad_evt_pkg;
    typedef logic [11:0] addr_type;
    typedef logic [31:0] word_type;
endpackage

// ==== core/quadrature_event_shortcuts.sv ====
// Event flags, event-to-task links, snapshot tasks and interrupt of the
// quadrature decoder.  Assumes decoder core supplies one-cycle pulses.
//
// Contract
// - Report event only when motion total nonzero
// - Double event only when double total nonzero
// - Overflow event on either total overflow
// - Halted event once decoder really stops
// - Set link bit connects event to task
// - Bit 0: report triggers clear both
// - Bit 1: new sample triggers stop
// - Bit 2: report triggers clear motion
// - Bit 3: report triggers stop
// - Bit 4: double triggers clear double
// - Bit 5: double triggers stop
// - Clear both snapshots and zeroes atomically
// - Clear motion snapshots and zeroes motion
// - Clear double snapshots and zeroes double
// - New sample event per written sample
`timescale 1ns/1ps
`include "quadrature_decoder_evt_map.svh"
module quadrature_event_shortcuts #(
    parameter int TOTAL_W = 16      // Width of both totals
) (
    input  wire logic              clk_sys,        // System clock, 50 MHz
    input  wire logic              rst,            // Sync reset, active high
    input  wire quad_evt_pkg::addr_type addr,      // Register byte address
    input  wire quad_evt_pkg::word_type wr_data,   // Write data
    input  wire logic              wr_en,          // Write strobe
    input  wire logic              rd_en,          // Read strobe
    output quad_evt_pkg::word_type rd_data,        // Read data, next cycle
    input  wire logic              report_due,     // Report period reached
    input  wire logic              sample_written, // New sample stored
    input  wire logic              motion_ovf,     // Motion total overflow
    input  wire logic              double_ovf,     // Double total overflow
    input  wire logic              decoder_halted, // Decoder halted pulse
    input  wire logic [TOTAL_W-1:0] motion_total,  // Running motion total
    input  wire logic [TOTAL_W-1:0] double_transition_total, // Double total
    input  wire logic              sw_clr_both,    // Software clear-both task
    input  wire logic              sw_clr_motion,  // Software clear-motion task
    input  wire logic              sw_clr_double,  // Software clear-double task
    output logic                   clr_motion_total, // Zero motion total
    output logic                   clr_double_total, // Zero double total
    output logic                   stop_task,      // Stop the decoder
    output logic [TOTAL_W-1:0]     motion_total_snapshot, // Motion snapshot
    output logic [TOTAL_W-1:0]     double_total_snapshot, // Double snapshot
    output logic                   irq             // Level interrupt
);
    import quad_evt_pkg::*;

    // ----------------------------------------
    // Event detection
    // ----------------------------------------
    logic [`EV_COUNT-1:0]    ev_pulse;
    logic [`EV_COUNT-1:0]    ev_flag;
    logic [`EV_COUNT-1:0]    ev_wr;
    logic [`LINKS_WIDTH-1:0] links_r;
    logic [`EV_COUNT-1:0]    irq_status_r;
    logic [`EV_COUNT-1:0]    irq_mask_r;
    logic                    do_both;
    logic                    do_motion;
    logic                    do_double;

    // Event pulses from decoder conditions
    always_comb begin
        ev_pulse[`EV_SAMPLE]   = sample_written;
        ev_pulse[`EV_REPORT]   = report_due && (motion_total != '0);
        ev_pulse[`EV_DOUBLE]   = report_due && (double_transition_total != '0);
        ev_pulse[`EV_OVERFLOW] = motion_ovf || double_ovf;
        ev_pulse[`EV_HALTED]   = decoder_halted;
    end

    // Address decode shared by flags and readback
    function automatic int ev_index(input addr_type a);
        if (a == `OFS_NEW_SAMPLE_EVENT) begin
            return `EV_SAMPLE;
        end else if (a == `OFS_MOTION_REPORT_EVT) begin
            return `EV_REPORT;
        end else if (a == `OFS_OVERFLOW_EVT) begin
            return `EV_OVERFLOW;
        end else if (a == `OFS_DOUBLE_EVT) begin
            return `EV_DOUBLE;
        end else if (a == `OFS_HALTED_EVT) begin
            return `EV_HALTED;
        end else begin
            return -1;
        end
    endfunction

    // ----------------------------------------
    // Event flag registers
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `EV_COUNT; gi++) begin : g_flag
            assign ev_wr[gi] = wr_en && (ev_index(addr) == gi);
            event_flag u_flag (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .set_pulse (ev_pulse[gi]),
                .wr_en     (ev_wr[gi]),
                .wr_bit    (wr_data[0]),
                .flag      (ev_flag[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Shortcut register and task routing
    // ----------------------------------------
    // Link register write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            links_r <= `LINKS_RESET;
        end else if (wr_en && addr == `OFS_LINKS) begin
            links_r <= wr_data[`LINKS_WIDTH-1:0];
        end
    end

    // Task triggers from links and software
    always_comb begin
        // report to clear both; sample to clear both
        do_both = sw_clr_both
            || (links_r[`LNK_REPORT_CLR_BOTH] && ev_pulse[`EV_REPORT])
            || (links_r[`LNK_SAMPLE_CLR_BOTH] && ev_pulse[`EV_SAMPLE]);
        do_motion = sw_clr_motion
            || (links_r[`LNK_REPORT_CLR_MOTION] && ev_pulse[`EV_REPORT]);
        do_double = sw_clr_double
            || (links_r[`LNK_DOUBLE_CLR_DOUBLE] && ev_pulse[`EV_DOUBLE]);
        stop_task = (links_r[`LNK_SAMPLE_STOP] && ev_pulse[`EV_SAMPLE])
            || (links_r[`LNK_REPORT_STOP] && ev_pulse[`EV_REPORT])
            || (links_r[`LNK_DOUBLE_STOP] && ev_pulse[`EV_DOUBLE]);
        clr_motion_total = do_both || do_motion;
        clr_double_total = do_both || do_double;
    end

    // ----------------------------------------
    // Snapshot registers
    // ----------------------------------------
    // motion snapshot in same cycle as clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            motion_total_snapshot <= '0;
        end else if (clr_motion_total) begin
            motion_total_snapshot <= motion_total;
        end
    end

    // double snapshot in same cycle as clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            double_total_snapshot <= '0;
        end else if (clr_double_total) begin
            double_total_snapshot <= double_transition_total;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status_r <= '0;
        end else if (wr_en && addr == `OFS_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~wr_data[`EV_COUNT-1:0]) | ev_pulse;
        end else begin
            irq_status_r <= irq_status_r | ev_pulse;
        end
    end

    // Mask register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_mask_r <= '0;
        end else if (wr_en && addr == `OFS_IRQ_MASK) begin
            irq_mask_r <= wr_data[`EV_COUNT-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Read data one cycle after strobe, zero elsewhere
    always_ff @(posedge clk_sys) begin
        if (rst || !rd_en) begin
            rd_data <= '0;
        end else if (ev_index(addr) >= 0) begin
            rd_data <= {31'h0, ev_flag[ev_index(addr)]};
        end else if (addr == `OFS_LINKS) begin
            rd_data <= {{(32-`LINKS_WIDTH){1'b0}}, links_r};
        end else if (addr == `OFS_IRQ_STATUS) begin
            rd_data <= {{(32-`EV_COUNT){1'b0}}, irq_status_r};
        end else if (addr == `OFS_IRQ_MASK) begin
            rd_data <= {{(32-`EV_COUNT){1'b0}}, irq_mask_r};
        end else if (addr == `OFS_MOTION_SNAP) begin
            rd_data <= 32'(motion_total_snapshot);
        end else if (addr == `OFS_DOUBLE_SNAP) begin
            rd_data <= 32'(double_total_snapshot);
        end else begin
            rd_data <= '0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_report_nonzero;
        @(posedge clk_sys) disable iff (rst)
        (report_due && motion_total != '0) |=> ev_flag[`EV_REPORT];
    endproperty
    a_report_nonzero: assert property (p_report_nonzero)
        else $error("report event missed");

    property p_report_zero;
        @(posedge clk_sys) disable iff (rst)
        (report_due && motion_total == '0 && !ev_flag[`EV_REPORT] && !ev_wr[`EV_REPORT])
            |=> !ev_flag[`EV_REPORT];
    endproperty
    a_report_zero: assert property (p_report_zero)
        else $error("report event without motion");

    property p_double_evt;
        @(posedge clk_sys) disable iff (rst)
        (report_due && double_transition_total != '0) |=> ev_flag[`EV_DOUBLE];
    endproperty
    a_double_evt: assert property (p_double_evt)
        else $error("double event missed");

    property p_overflow;
        @(posedge clk_sys) disable iff (rst)
        (motion_ovf || double_ovf) |=> ev_flag[`EV_OVERFLOW];
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow event missed");

    property p_halted;
        @(posedge clk_sys) disable iff (rst)
        decoder_halted |=> ev_flag[`EV_HALTED];
    endproperty
    a_halted: assert property (p_halted)
        else $error("halted event missed");

    property p_sticky;
        @(posedge clk_sys) disable iff (rst)
        (ev_flag[`EV_SAMPLE] && !ev_wr[`EV_SAMPLE]) |=> ev_flag[`EV_SAMPLE];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sample flag dropped without write");

    property p_stop_report;
        @(posedge clk_sys) disable iff (rst)
        (links_r[`LNK_REPORT_STOP] && report_due && motion_total != '0) |-> stop_task;
    endproperty
    a_stop_report: assert property (p_stop_report)
        else $error("report stop link failed");

    property p_no_link;
        @(posedge clk_sys) disable iff (rst)
        (links_r == '0) |-> !stop_task;
    endproperty
    a_no_link: assert property (p_no_link)
        else $error("stop without link");

    property p_snap_motion;
        @(posedge clk_sys) disable iff (rst)
        clr_motion_total |=> motion_total_snapshot == $past(motion_total);
    endproperty
    a_snap_motion: assert property (p_snap_motion)
        else $error("motion snapshot wrong");

    property p_snap_double;
        @(posedge clk_sys) disable iff (rst)
        clr_double_total |=> double_total_snapshot == $past(double_transition_total);
    endproperty
    a_snap_double: assert property (p_snap_double)
        else $error("double snapshot wrong");

    property p_stop_double;
        @(posedge clk_sys) disable iff (rst)
        (links_r[`LNK_DOUBLE_STOP] && report_due && double_transition_total != '0)
            |-> stop_task;
    endproperty
    a_stop_double: assert property (p_stop_double)
        else $error("double stop link failed");

    property p_both;
        @(posedge clk_sys) disable iff (rst)
        (links_r[`LNK_SAMPLE_CLR_BOTH] && sample_written)
            |-> clr_motion_total && clr_double_total;
    endproperty
    a_both: assert property (p_both)
        else $error("sample clear both failed");
endmodule

// ==== verif/quadrature_event_shortcuts_test.sv ====
// Self-checking bench for the event flags, links, snapshots and interrupt.
// Assumes the core files are compiled first and the map header is on the include path.
`timescale 1ns/1ps
`include "quadrature_decoder_evt_map.svh"
module quadrature_event_shortcuts_test;
    import quad_evt_pkg::*;
    localparam int TW = 16;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic          clk_sys    = 1'b0;
    logic          rst        = 1'b1;
    addr_type      addr       = '0;
    word_type      wr_data    = '0;
    logic          wr_en      = 1'b0;
    logic          rd_en      = 1'b0;
    logic [7:0]    ev         = '0;   // Pulse inputs, one bit each
    logic [TW-1:0] mot        = '0;
    logic [TW-1:0] dbl        = '0;
    word_type      rd_data;
    logic          clr_m;
    logic          clr_d;
    logic          stop;
    logic          irq;
    logic [TW-1:0] snap_m;
    logic [TW-1:0] snap_d;
    logic [TW-1:0] exp_ms     = '0;   // Expected snapshots
    logic [TW-1:0] exp_ds     = '0;
    int            errors     = 0;
    int            num_checks = 0;

    quadrature_event_shortcuts #(.TOTAL_W(TW)) uut (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .report_due(ev[0]), .sample_written(ev[1]), .motion_ovf(ev[2]),
        .double_ovf(ev[3]), .decoder_halted(ev[4]), .motion_total(mot),
        .double_transition_total(dbl), .sw_clr_both(ev[5]), .sw_clr_motion(ev[6]),
        .sw_clr_double(ev[7]), .clr_motion_total(clr_m), .clr_double_total(clr_d),
        .stop_task(stop), .motion_total_snapshot(snap_m),
        .double_total_snapshot(snap_d), .irq(irq)
    );

    // Free-running 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle register write
    task automatic wr(input addr_type a, input word_type d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
    endtask

    // One-cycle read, data checked in the following cycle
    task automatic rd(input addr_type a, input word_type exp, input string name);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(name, exp, rd_data);
    endtask

    // One-cycle pulse on input i with given totals; checks task outputs and snapshots
    task automatic pulse(input int i, input logic [TW-1:0] m, input logic [TW-1:0] d,
                         input logic em, input logic ed, input logic es);
        @(posedge clk_sys);
        ev  <= 8'h01 << i;
        mot <= m;
        dbl <= d;
        #1;
        chk("clr_motion_total", {31'h0, em}, {31'h0, clr_m});
        chk("clr_double_total", {31'h0, ed}, {31'h0, clr_d});
        chk("stop_task", {31'h0, es}, {31'h0, stop});
        @(posedge clk_sys);
        ev <= 8'h00;
        #1;
        chk("motion_total_snapshot", 32'(exp_ms), 32'(snap_m));
        chk("double_total_snapshot", 32'(exp_ds), 32'(snap_d));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        addr_type regs[8] = '{`OFS_NEW_SAMPLE_EVENT, `OFS_MOTION_REPORT_EVT, `OFS_OVERFLOW_EVT,
                              `OFS_DOUBLE_EVT, `OFS_HALTED_EVT, `OFS_LINKS, `OFS_IRQ_MASK,
                              12'h0fc};
        for (int k = 0; k < 8; k++) begin
            rd(regs[k], 32'h0, "reset or unmapped read");
        end
        chk("irq", 32'h0, {31'h0, irq});
        wr(`OFS_LINKS, 32'hffff_ffff);
        rd(`OFS_LINKS, 32'h0000_007f, "event_task_links");
        wr(`OFS_LINKS, 32'h0);
    endtask

    // Report and double events only for nonzero totals
    task automatic t_gate;
        pulse(0, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
        rd(`OFS_MOTION_REPORT_EVT, 32'h0, "motion_report_event");
        rd(`OFS_DOUBLE_EVT, 32'h0, "double_transition_event");
        pulse(0, 16'h0005, 16'h0000, 1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge clk_sys);
        rd(`OFS_MOTION_REPORT_EVT, 32'h1, "motion_report_event");
        rd(`OFS_DOUBLE_EVT, 32'h0, "double_transition_event");
        wr(`OFS_MOTION_REPORT_EVT, 32'h0);
        rd(`OFS_MOTION_REPORT_EVT, 32'h0, "motion_report_event");
        pulse(0, 16'h0000, 16'h0003, 1'b0, 1'b0, 1'b0);
        rd(`OFS_DOUBLE_EVT, 32'h1, "double_transition_event");
        rd(`OFS_MOTION_REPORT_EVT, 32'h0, "motion_report_event");
        wr(`OFS_DOUBLE_EVT, 32'h0);
    endtask

    // Sample and halt set their own flags; both overflow sources set the overflow flag
    task automatic t_flags;
        addr_type ofs[5] = '{`OFS_MOTION_REPORT_EVT, `OFS_NEW_SAMPLE_EVENT, `OFS_OVERFLOW_EVT,
                             `OFS_OVERFLOW_EVT, `OFS_HALTED_EVT};
        for (int i = 1; i < 5; i++) begin
            pulse(i, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
            rd(ofs[i], 32'h1, "event flag set");
            wr(ofs[i], 32'h0);
            rd(ofs[i], 32'h0, "event flag cleared");
        end
    endtask

    // Each link bit alone, then no link, then the software tasks
    task automatic t_links;
        logic [TW-1:0] m;
        logic [TW-1:0] d;
        logic          em;
        logic          ed;
        for (int b = 0; b < 8; b++) begin
            wr(`OFS_LINKS, (b < 7) ? (32'h1 << b) : 32'h0);
            m  = (b == 4 || b == 5) ? 16'h0000 : 16'h0010 + 16'(b);
            d  = 16'h0300 + 16'(b);
            em = b inside {0, 2, 6};
            ed = b inside {0, 4, 6};
            if (em) exp_ms = m;
            if (ed) exp_ds = d;
            pulse((b == 1 || b == 6) ? 1 : 0, m, d, em, ed, b inside {1, 3, 5});
        end
        for (int i = 5; i < 8; i++) begin
            m  = 16'h0a00 + 16'(i);
            d  = 16'h0b00 + 16'(i);
            em = (i != 7);
            ed = (i != 6);
            if (em) exp_ms = m;
            if (ed) exp_ds = d;
            pulse(i, m, d, em, ed, 1'b0);
        end
        rd(`OFS_MOTION_SNAP, 32'(exp_ms), "motion snapshot read");
        rd(`OFS_DOUBLE_SNAP, 32'(exp_ds), "double snapshot read");
    endtask

    // Interrupt raised, masked and cleared
    task automatic t_irq;
        wr(`OFS_IRQ_STATUS, 32'h1f);
        rd(`OFS_IRQ_STATUS, 32'h0, "interrupt status");
        wr(`OFS_IRQ_MASK, 32'h10);
        rd(`OFS_IRQ_MASK, 32'h10, "interrupt mask");
        chk("irq idle", 32'h0, {31'h0, irq});
        pulse(4, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 32'h0);
        #1;
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(`OFS_IRQ_STATUS, 32'h10, "interrupt status");
        wr(`OFS_IRQ_MASK, 32'h10);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`OFS_IRQ_STATUS, 32'h10);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask

    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Guard against a hung run
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_gate();
        t_flags();
        t_links();
        t_irq();
        print_verdict();
    end
endmodule
